// file: acfr_top.sv
`timescale 1ns/1ps

// What this block does
// [R1] Right justify: high result top six bits zero
// [R2] Left justify: low result bottom six bits zero
// [R3] Clock select picks divisor or RC oscillator
// [R4] Negative reference: ground or external pin
// [R5] Positive reference: supply, pin, fixed; 01 reserved
// [R6] Left format: result 9..2 into high
// [R7] Left format: result 1..0 into low 7..6
// [R8] Right format: result 9..8 into high 1..0
// [R9] Right format: result 7..0 into low
// [R10] Software waits acquisition interval before starting
// [R11] Config bit 3 ignores writes, reads zero
// [R12] Config clears on reset; results keep contents
// [R13] Completion clears busy, sets flag, loads results
// [R14] Justification applied only when result loads

module acfr_top
(
  // Clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // APB slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // Analog converter side
  input  wire logic                  rc_tick,
  input  wire acfr_pkg::acfr_conv_in_t conv_in,
  output acfr_pkg::acfr_conv_out_t   conv_out,
  // Interrupt
  output logic                       irq
);

  import acfr_pkg::*;

  // Register state
  logic [4:0]     channel_select;
  logic           converter_enable;
  logic           busy;
  acfr_config_t   cfg;
  logic [7:0]     result_high;
  logic [7:0]     result_low;
  logic [0:0]     int_status;
  logic [0:0]     int_mask;
  logic           start_pulse;
  logic           abort_pulse;

  // Next values
  logic           next_busy;
  logic [0:0]     next_int_status;
  logic [7:0]     next_result_high;
  logic [7:0]     next_result_low;

  // Bus decode
  logic           setup_phase;
  logic           access_phase;
  logic           wr_access;
  logic           hit_control;
  logic           hit_config;
  logic           hit_result_high;
  logic           hit_result_low;
  logic           hit_int_status;
  logic           hit_int_mask;
  logic           hit_any;
  logic           wr_control;
  logic           wr_config;
  logic           wr_result_high;
  logic           wr_result_low;
  logic           wr_int_status;
  logic           wr_int_mask;

  // Control write fields
  logic           wdata_enable;
  logic           wdata_go;
  logic           ctrl_run;
  logic           ctrl_stop;
  logic           start_req;
  logic           abort_req;

  // Formatted result
  logic [ACFR_RESULT_W-1:0] res;
  logic [7:0]     fmt_high;
  logic [7:0]     fmt_low;

  // Read path
  logic [7:0]     control_view;
  logic [7:0]     config_view;
  logic [7:0]     read_byte;
  logic [7:0]     status_view;
  logic [7:0]     mask_view;
  logic           read_setup;
  logic           conv_tick;

  // Config write data and flag strobes
  acfr_config_t   cfg_wdata;
  logic           set_done;
  logic           clear_done;

  // Zero-wait APB: every access completes in its first access cycle
  assign setup_phase  = psel && !penable;
  assign access_phase = psel && penable;
  assign wr_access    = access_phase && pwrite;
  assign read_setup   = setup_phase && !pwrite;
  assign pready       = 1'b1;

  // Address decode
  assign hit_control     = (paddr == ACFR_OFF_CONTROL);
  assign hit_config      = (paddr == ACFR_OFF_CONFIG);
  assign hit_result_high = (paddr == ACFR_OFF_RESULT_HIGH);
  assign hit_result_low  = (paddr == ACFR_OFF_RESULT_LOW);
  assign hit_int_status  = (paddr == ACFR_OFF_INT_STATUS);
  assign hit_int_mask    = (paddr == ACFR_OFF_INT_MASK);
  assign hit_any         = hit_control || hit_config || hit_result_high
                        || hit_result_low || hit_int_status || hit_int_mask;
  assign pslverr         = access_phase && !hit_any;

  // Write strobes
  assign wr_control     = wr_access && hit_control;
  assign wr_config      = wr_access && hit_config;
  assign wr_result_high = wr_access && hit_result_high;
  assign wr_result_low  = wr_access && hit_result_low;
  assign wr_int_status  = wr_access && hit_int_status;
  assign wr_int_mask    = wr_access && hit_int_mask;

  // Start needs the converter enabled and idle; clearing go aborts
  assign wdata_enable = pwdata[ACFR_CTRL_ENABLE_BIT];
  assign wdata_go     = pwdata[ACFR_CTRL_GO_BIT];
  assign ctrl_run     = wdata_go && wdata_enable;
  assign ctrl_stop    = !ctrl_run;
  assign start_req    = wr_control && ctrl_run && !busy && !conv_in.done;
  assign abort_req    = wr_control && busy && ctrl_stop;

  // Control register and one-cycle start/abort pulses
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      channel_select   <= ACFR_CONTROL_RESET[6:2];
      converter_enable <= ACFR_CONTROL_RESET[0];
      start_pulse      <= 1'b0;
      abort_pulse      <= 1'b0;
    end
    else
    begin
      start_pulse <= start_req;
      abort_pulse <= abort_req;
      if (wr_control)
      begin
        channel_select   <= pwdata[ACFR_CTRL_CHAN_LSB +: 5];
        converter_enable <= wdata_enable;
      end
    end
  end

  // Busy flag: completion clears it, a start sets it
  always_comb
  begin
    next_busy = busy;
    if (conv_in.done || abort_req)
      next_busy = 1'b0; // R13
    else if (start_req)
      next_busy = 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      busy <= ACFR_CONTROL_RESET[ACFR_CTRL_GO_BIT];
    else
      busy <= next_busy;
  end

  // Config write data; the unused bit never stores a one
  always_comb
  begin
    cfg_wdata                      = acfr_config_t'(pwdata[7:0]);
    cfg_wdata[ACFR_CFG_UNUSED_BIT] = 1'b0; // R11
  end

  // Configuration register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cfg <= acfr_config_t'(ACFR_CONFIG_RESET); // R12
    else if (wr_config)
      cfg <= cfg_wdata;
  end

  // Result formatting taken from the live data at load time
  assign res = conv_in.data;
  assign fmt_high = cfg.justification_select
                  ? {{ACFR_PAD_W{1'b0}}, res[9:8]} // R1 R8
                  : res[9:2];                      // R6
  assign fmt_low  = cfg.justification_select
                  ? res[7:0]                       // R9
                  : {res[1:0], {ACFR_PAD_W{1'b0}}}; // R2 R7

  // Result load on completion; software writes otherwise
  always_comb
  begin
    next_result_high = result_high;
    next_result_low  = result_low;
    if (conv_in.done)
    begin
      next_result_high = fmt_high; // R13 R14
      next_result_low  = fmt_low;  // R13 R14
    end
    else
    begin
      if (wr_result_high)
        next_result_high = pwdata[7:0];
      if (wr_result_low)
        next_result_low = pwdata[7:0];
    end
  end

  // Results are not touched by reset
  always_ff @(posedge pclk)
  begin
    result_high <= next_result_high; // R12
    result_low  <= next_result_low;  // R12
  end

  // Flag event and software clear strobes
  assign set_done   = conv_in.done;
  assign clear_done = wr_int_status && pwdata[ACFR_INT_DONE_BIT];

  // Sticky completion flag, write one to clear, set wins
  always_comb
  begin
    next_int_status = int_status;
    if (clear_done)
      next_int_status[ACFR_INT_DONE_BIT] = 1'b0;
    if (set_done)
      next_int_status[ACFR_INT_DONE_BIT] = 1'b1; // R13
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      int_status <= ACFR_INT_RESET;
      int_mask   <= ACFR_INT_RESET;
    end
    else
    begin
      int_status <= next_int_status;
      if (wr_int_mask)
        int_mask <= pwdata[ACFR_INT_DONE_BIT +: 1];
    end
  end

  // Level interrupt from unmasked status
  assign irq = |(int_status & int_mask);

  // Register views for reads
  assign control_view = {1'b0, channel_select, busy, converter_enable};
  assign config_view  = cfg; // R11
  assign status_view  = {7'h00, int_status};
  assign mask_view    = {7'h00, int_mask};

  always_comb
  begin
    read_byte = 8'h00;
    case (1'b1)
      hit_control:     read_byte = control_view;
      hit_config:      read_byte = config_view;
      hit_result_high: read_byte = result_high;
      hit_result_low:  read_byte = result_low;
      hit_int_status:  read_byte = status_view;
      hit_int_mask:    read_byte = mask_view;
      default:         read_byte = 8'h00;
    endcase
  end

  // Read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (read_setup)
      prdata <= {24'h00_0000, read_byte};
  end

  // Conversion clock enable
  acfr_clock_divider u_divider
  (
    .pclk    (pclk),
    .presetn (presetn),
    .sel     (cfg.conversion_clock_select), // R3
    .rc_tick (rc_tick),
    .tick    (conv_tick)
  );

  // Controls to the analog converter; software times acquisition itself
  assign conv_out.converter_enable          = converter_enable;
  assign conv_out.start                     = start_pulse; // R10
  assign conv_out.abort                     = abort_pulse;
  assign conv_out.busy                      = busy;
  assign conv_out.clk_en                    = conv_tick && converter_enable;
  assign conv_out.channel_select            = channel_select;
  assign conv_out.positive_reference_select = cfg.positive_reference_select; // R5
  assign conv_out.negative_reference_select = cfg.negative_reference_select; // R4

endmodule

// file: acfr_pkg.sv
package acfr_pkg;

  // Register byte offsets on the APB
  localparam logic [7:0] ACFR_OFF_CONTROL     = 8'h00;
  localparam logic [7:0] ACFR_OFF_CONFIG      = 8'h04;
  localparam logic [7:0] ACFR_OFF_RESULT_HIGH = 8'h08;
  localparam logic [7:0] ACFR_OFF_RESULT_LOW  = 8'h0c;
  localparam logic [7:0] ACFR_OFF_INT_STATUS  = 8'h10;
  localparam logic [7:0] ACFR_OFF_INT_MASK    = 8'h14;

  // Values after reset
  localparam logic [7:0] ACFR_CONTROL_RESET = 8'h00;
  localparam logic [7:0] ACFR_CONFIG_RESET  = 8'h00;
  localparam logic [0:0] ACFR_INT_RESET     = 1'h0;

  // Field positions
  localparam int ACFR_CTRL_ENABLE_BIT = 0;
  localparam int ACFR_CTRL_GO_BIT     = 1;
  localparam int ACFR_CTRL_CHAN_LSB   = 2;
  localparam int ACFR_CFG_UNUSED_BIT  = 3;
  localparam int ACFR_INT_DONE_BIT    = 0;

  // Result width and the width of the unused padding
  localparam int ACFR_RESULT_W = 10;
  localparam int ACFR_PAD_W    = 6;

  // Conversion clock select codes
  localparam logic [2:0] ACFR_CS_DIV2  = 3'h0;
  localparam logic [2:0] ACFR_CS_DIV8  = 3'h1;
  localparam logic [2:0] ACFR_CS_DIV32 = 3'h2;
  localparam logic [2:0] ACFR_CS_RC_A  = 3'h3;
  localparam logic [2:0] ACFR_CS_DIV4  = 3'h4;
  localparam logic [2:0] ACFR_CS_DIV16 = 3'h5;
  localparam logic [2:0] ACFR_CS_DIV64 = 3'h6;
  localparam logic [2:0] ACFR_CS_RC_B  = 3'h7;

  // Positive reference codes
  localparam logic [1:0] ACFR_PREF_SUPPLY   = 2'h0;
  localparam logic [1:0] ACFR_PREF_RESERVED = 2'h1;
  localparam logic [1:0] ACFR_PREF_PIN      = 2'h2;
  localparam logic [1:0] ACFR_PREF_FIXED    = 2'h3;

  // Configuration register layout
  typedef struct packed {
    logic       justification_select;
    logic [2:0] conversion_clock_select;
    logic       unused;
    logic       negative_reference_select;
    logic [1:0] positive_reference_select;
  } acfr_config_t;

  // Result coming back from the analog converter
  typedef struct packed {
    logic                     done;
    logic [ACFR_RESULT_W-1:0] data;
  } acfr_conv_in_t;

  // Controls going out to the analog converter
  typedef struct packed {
    logic       converter_enable;
    logic       start;
    logic       abort;
    logic       busy;
    logic       clk_en;
    logic [4:0] channel_select;
    logic [1:0] positive_reference_select;
    logic       negative_reference_select;
  } acfr_conv_out_t;

endpackage

// file: acfr_clock_divider.sv
`timescale 1ns/1ps

module acfr_clock_divider
(
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Selection and RC oscillator tick
  input  wire logic [2:0] sel,
  input  wire logic       rc_tick,
  // Conversion clock enable
  output logic            tick
);

  import acfr_pkg::*;

  logic [5:0] count;
  logic [5:0] terminal;
  logic       use_rc;
  logic       wrap;

  // Terminal count per divisor
  always_comb
  begin
    use_rc   = 1'b0;
    terminal = 6'h01;
    case (sel)
      ACFR_CS_DIV2:  terminal = 6'h01;
      ACFR_CS_DIV4:  terminal = 6'h03;
      ACFR_CS_DIV8:  terminal = 6'h07;
      ACFR_CS_DIV16: terminal = 6'h0f;
      ACFR_CS_DIV32: terminal = 6'h1f;
      ACFR_CS_DIV64: terminal = 6'h3f;
      ACFR_CS_RC_A:  use_rc   = 1'b1;
      ACFR_CS_RC_B:  use_rc   = 1'b1;
      default:       terminal = 6'h01;
    endcase
  end

  assign wrap = (count >= terminal);

  // Free running divider; restarts when the divisor is lowered
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      count <= 6'h00;
    else if (wrap || use_rc)
      count <= 6'h00;
    else
      count <= count + 6'h01;
  end

  // One-cycle enable, or the RC tick when selected
  assign tick = use_rc ? rc_tick : wrap;

endmodule

// file: acfr_chk_sva.sv
`timescale 1ns/1ps

// Port-level checks for the converter block
module acfr_chk
(
  // Clock and reset
  input wire logic                     pclk,
  input wire logic                     presetn,
  // Register bus
  input wire logic                     psel,
  input wire logic                     penable,
  input wire logic                     pwrite,
  input wire logic [7:0]               paddr,
  input wire logic [31:0]              pwdata,
  input wire logic [31:0]              prdata,
  // Converter side and interrupt
  input wire logic                     rc_tick,
  input wire acfr_pkg::acfr_conv_in_t  conv_in,
  input wire acfr_pkg::acfr_conv_out_t conv_out,
  input wire logic                     irq
);
  import acfr_pkg::*;

  logic [7:0] cfg_q;
  logic [1:0] fmt_q;
  logic       mask_q;
  wire        mask_wr = psel && penable && pwrite && paddr == ACFR_OFF_INT_MASK;
  wire        cfg_wr = psel && penable && pwrite && paddr == ACFR_OFF_CONFIG;

  // Shadow of the config register
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      cfg_q <= 8'h00;
    else if (cfg_wr)
      cfg_q <= pwdata[7:0];

  // Format of the last load, dropped on a software write
  always_ff @(posedge pclk)
    if (conv_in.done)
      fmt_q <= {cfg_q[7], !cfg_q[7]};
    else if (psel && penable && pwrite && paddr[7:3] == 5'h01)
      fmt_q <= 2'h0;

  // Shadow of the interrupt mask
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      mask_q <= 1'b0;
    else if (mask_wr)
      mask_q <= pwdata[0];

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Read access with no load racing it
  sequence s_rd(logic [7:0] a, logic c);
    psel && penable && !pwrite && paddr == a && c && !$past(conv_in.done);
  endsequence

  // Start: busy rises with the pulse, which lasts one cycle
  sequence s_start;
    !$past(conv_out.busy) && conv_out.busy ##1 !conv_out.start;
  endsequence

  property p_start;
    conv_out.start |-> s_start;
  endproperty
  property p_irq_set;
    conv_in.done && mask_q && !mask_wr |=> irq;
  endproperty
  property p_irq_off;
    !mask_q |-> !irq;
  endproperty
  property p_reset;
    $rose(presetn) |-> !irq && !conv_out.busy && !conv_out.start;
  endproperty
  property p_cfg_rd;
    s_rd(ACFR_OFF_CONFIG, 1'b1) |-> prdata[3] == 1'b0 && prdata[31:8] == 24'h0;
  endproperty
  property p_pref;
    cfg_wr |=> conv_out.positive_reference_select == cfg_q[1:0]
      && conv_out.negative_reference_select == cfg_q[2];
  endproperty
  property p_gate;
    !conv_out.converter_enable |-> !conv_out.clk_en;
  endproperty
  property p_rc;
    conv_out.converter_enable && cfg_q[5:4] == 2'h3 |-> conv_out.clk_en == rc_tick;
  endproperty
  property p_done;
    conv_in.done && conv_out.busy |=> !conv_out.busy;
  endproperty
  property p_right;
    s_rd(ACFR_OFF_RESULT_HIGH, fmt_q[1]) |-> prdata[7:2] == 6'h00;
  endproperty
  property p_left;
    s_rd(ACFR_OFF_RESULT_LOW, fmt_q[0]) |-> prdata[5:0] == 6'h00;
  endproperty

  a_reset: assert property (p_reset) else $error("state not clear after reset");
  a_cfg_rd: assert property (p_cfg_rd) else $error("config bit 3 read nonzero");
  a_pref: assert property (p_pref) else $error("reference select wrong");
  a_gate: assert property (p_gate) else $error("clock enable while off");
  a_rc: assert property (p_rc) else $error("rc clock not passed");
  a_done: assert property (p_done) else $error("busy kept after done");
  a_right: assert property (p_right) else $error("high pad nonzero");
  a_left: assert property (p_left) else $error("low pad nonzero");
  a_start: assert property (p_start) else $error("start pulse or busy wrong");
  a_irq_set: assert property (p_irq_set) else $error("irq not raised on done");
  a_irq_off: assert property (p_irq_off) else $error("irq while masked");
endmodule

bind acfr_top acfr_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .rc_tick(rc_tick), .conv_in(conv_in), .conv_out(conv_out),
  .irq(irq));

// file: tb.sv
`timescale 1ns/1ps

// Self-checking bench for the converter block
module tb;
  import acfr_pkg::*;
  logic           pclk = 1'b0;
  logic           presetn = 1'b0;
  logic           psel = 1'b0;
  logic           penable = 1'b0;
  logic           pwrite = 1'b0;
  logic           rc_tick = 1'b0;
  logic [7:0]     paddr = 8'h00;
  logic [31:0]    pwdata = 32'h0;
  logic [31:0]    prdata, rd, v;
  logic           pready, pslverr, irq, er, j;
  logic [9:0]     d;
  logic [15:0]    f;
  logic [31:0]    s = 32'd6769;
  acfr_conv_in_t  conv_in = '0;
  acfr_conv_out_t conv_out;
  int             bad_count = 0;
  int             num_checks = 0;
  int             cyc = 0;
  int             n, e;

  // Clock
  always #50 pclk = ~pclk;

  acfr_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rc_tick(rc_tick), .conv_in(conv_in),
    .conv_out(conv_out), .irq(irq));

  function automatic logic [31:0] rnd();
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  // Expected high and low bytes
  function automatic logic [15:0] fmt(input logic jr, input logic [9:0] dv);
    return jr ? {6'h00, dv} : {dv, 6'h00};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // One bus transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Start and complete one conversion
  task automatic conv(input logic [9:0] dv);
    apb(1'b1, ACFR_OFF_CONTROL, 32'h01);
    repeat (8) @(posedge pclk);
    apb(1'b1, ACFR_OFF_CONTROL, 32'h03);
    @(negedge pclk);
    chk({conv_out.start, conv_out.busy}, 2'h3);
    repeat (3) @(posedge pclk);
    conv_in <= {1'b1, dv};
    @(posedge pclk);
    conv_in <= '0;
    @(negedge pclk);
    chk(conv_out.busy, 1'b0);
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Cycle ceiling
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      bad_count++;
      print_verdict();
    end
  end

  // Main sequence
  initial
  begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ACFR_OFF_CONFIG, 32'h0);
    chk(rd, 32'h0);
    for (int i = 0; i < 8; i++)
    begin
      v = (rnd() & 32'hf8) | i;
      if (v[1:0] == 2'h1)
        v[1:0] = 2'h2;
      apb(1'b1, ACFR_OFF_CONFIG, v);
      apb(1'b0, ACFR_OFF_CONFIG, 32'h0);
      chk(rd, v & 32'hf7);
      chk({conv_out.positive_reference_select, conv_out.negative_reference_select},
        {v[1:0], v[2]});
    end
    apb(1'b1, ACFR_OFF_CONTROL, 32'h01);
    for (int c = 0; c < 8; c++)
    begin
      apb(1'b1, ACFR_OFF_CONFIG, c << 4);
      repeat (70) @(posedge pclk);
      n = 0;
      e = 0;
      repeat (128)
      begin
        @(posedge pclk);
        n += conv_out.clk_en;
        e += rc_tick;
        v = rnd();
        rc_tick <= v[0];
      end
      chk(n, c[1:0] == 2'h3 ? e : 128 >> (2 * c[1:0] + 1 + c[2]));
    end
    apb(1'b1, ACFR_OFF_INT_MASK, 32'h01);
    apb(1'b0, ACFR_OFF_INT_MASK, 32'h0);
    chk(rd, 32'h01);
    for (int k = 0; k < 8; k++)
    begin
      v = rnd();
      d = k < 4 ? {10{k[1]}} : v[9:0];
      j = k[0];
      f = fmt(j, d);
      apb(1'b1, ACFR_OFF_CONFIG, {j, 7'h00});
      conv(d);
      apb(1'b0, ACFR_OFF_RESULT_HIGH, 32'h0);
      chk(rd, f[15:8]);
      apb(1'b0, ACFR_OFF_RESULT_LOW, 32'h0);
      chk(rd, f[7:0]);
      apb(1'b0, ACFR_OFF_CONTROL, 32'h0);
      chk(rd, 32'h01);
      chk(irq, 1'b1);
      apb(1'b1, ACFR_OFF_INT_STATUS, 32'h01);
      apb(1'b0, ACFR_OFF_INT_STATUS, 32'h0);
      chk(rd, 32'h0);
      chk(irq, 1'b0);
    end
    // Refused start, channel readback, abort of a running conversion
    v = rnd();
    apb(1'b1, ACFR_OFF_CONTROL, {25'h0, v[4:0], 2'h2});
    @(negedge pclk);
    chk({conv_out.start, conv_out.busy, conv_out.converter_enable}, 3'h0);
    chk(conv_out.channel_select, v[4:0]);
    apb(1'b0, ACFR_OFF_CONTROL, 32'h0);
    chk(rd, {25'h0, v[4:0], 2'h0});
    apb(1'b1, ACFR_OFF_CONTROL, 32'h03);
    apb(1'b1, ACFR_OFF_CONTROL, 32'h01);
    @(negedge pclk);
    chk({conv_out.abort, conv_out.busy}, 2'h2);
    apb(1'b0, ACFR_OFF_CONTROL, 32'h0);
    chk(rd, 32'h01);
    apb(1'b1, ACFR_OFF_INT_MASK, 32'h0);
    conv(10'h155);
    chk(irq, 1'b0);
    apb(1'b0, ACFR_OFF_INT_STATUS, 32'h0);
    chk(rd, 32'h01);
    apb(1'b1, ACFR_OFF_CONFIG, 32'h0);
    apb(1'b0, ACFR_OFF_RESULT_HIGH, 32'h0);
    chk(rd, 32'h01);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ACFR_OFF_CONFIG, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, ACFR_OFF_RESULT_LOW, 32'h0);
    chk(rd, 32'h55);
    apb(1'b1, ACFR_OFF_RESULT_HIGH, 32'ha5);
    apb(1'b0, ACFR_OFF_RESULT_HIGH, 32'h0);
    chk(rd, 32'ha5);
    apb(1'b0, ACFR_OFF_INT_MASK, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h18, 32'h0);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
    print_verdict();
  end
endmodule
